// ===== rtl/pchec_cfg.sv
// How it works
// - Latency timer byte at 0x0C bits 15:8 reads zero, writes ignored.
// - Header type byte reads 00h; bits 31:24 read zero.
// - BAR0 is a 64-byte I/O base, resets to 00000001h.
// - BAR1 is a 4096-byte memory base, resets to 00000000h.
// - Subsystem vendor code is host read-only, reset 0000h, preload may replace.
// - Subsystem device code is host read-only, reset 0000h, preload may replace.
// - Capability pointer read-only, reset 00h, preload may change; upper bits zero.
// - Interrupt routing byte is plain read/write storage, reset 00h.
// - Interrupt pin byte reads 01h; bits 31:16 read zero.
// - Setting start launches one ROM cycle at the word address field.
// - Command 01b writes, 10b reads; 00b and 11b are reserved.
// - Busy bit is high exactly while a ROM access is in progress.
// - Preload enable starts preload unless the same write launches a ROM cycle; status bits report disabled, bad sum, normal.
// - Bits 31:16 hold the word that a ROM write stores.
// - Four channels own 8-byte blocks at BAR0 plus 00h, 08h, 10h, 18h.
// - Block offsets 01h, 03h, 04h read/write; 05h, 06h read-only.
// - Offsets 00h and 02h split by direction: data and cause/queue control.
// - I/O claims need command bit 0, memory claims command bit 1.
`timescale 1ns/1ns
`default_nettype none
module pchec_cfg
    import pchec_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset,
    // Configuration access
    input  wire logic         cfg_valid,
    input  wire pchec_cfg_s   cfg_in,
    output logic              cfg_ack_q,
    output logic [31:0]       cfg_rdata_q,
    // I/O and memory space access
    input  wire logic         acc_valid,
    input  wire pchec_acc_s   acc_in,
    output pchec_claim_s      uart_claim_q,
    output logic              mem_hit_q,
    output logic [11:0]       mem_ofs_q,
    // Serial ROM engine
    output logic              rom_go_q,
    output logic [1:0]        rom_cmd_q,
    output logic [7:0]        rom_addr_q,
    output logic [15:0]       rom_wdata_q,
    input  wire logic         rom_done,
    input  wire logic [15:0]  rom_rdata,
    output logic              preload_go_q,
    input  wire logic         preload_done,
    input  wire pchec_pre_s   preload_res,
    // Routing byte for the interrupt logic
    output logic [7:0]        irq_line_q
);

    logic                     cmd_io_q;
    logic                     cmd_mem_q;
    logic [31:PCHEC_BAR0_LSB] bar0_q;
    logic [31:PCHEC_BAR1_LSB] bar1_q;
    logic [15:0]              sub_vendor_q;
    logic [15:0]              sub_device_q;
    logic [7:0]               cap_ptr_q;
    logic                     start_q;
    logic                     preload_en_q;
    logic                     busy_q;
    logic [1:0]               pre_status_q;
    pchec_rom_e               state_q;

    // Access decode
    wire        cfg_wr      = cfg_valid & cfg_in.we;
    wire        cfg_rd      = cfg_valid & ~cfg_in.we;
    wire [5:0]  dw          = cfg_in.addr[7:2];
    wire        hit_cmd     = dw == PCHEC_OFS_CMD[7:2];
    wire        hit_lat     = dw == PCHEC_OFS_LAT[7:2];
    wire        hit_bar0    = dw == PCHEC_OFS_BAR0[7:2];
    wire        hit_bar1    = dw == PCHEC_OFS_BAR1[7:2];
    wire        hit_sub     = dw == PCHEC_OFS_SUBSYS[7:2];
    wire        hit_cap     = dw == PCHEC_OFS_CAP[7:2];
    wire        hit_irq     = dw == PCHEC_OFS_IRQ[7:2];
    wire        hit_rc      = dw == PCHEC_OFS_ROMCTL[7:2];
    wire [31:0] wmask       = {{8{cfg_in.be[3]}}, {8{cfg_in.be[2]}}, {8{cfg_in.be[1]}}, {8{cfg_in.be[0]}}};
    wire [31:0] bar0_full   = {bar0_q, {PCHEC_BAR0_LSB{1'b0}}} | PCHEC_BAR0_RST;
    wire [31:0] bar1_full   = {bar1_q, {PCHEC_BAR1_LSB{1'b0}}} | PCHEC_BAR1_RST;
    wire [31:0] bar0_wr     = (bar0_full & ~wmask) | (cfg_in.wdata & wmask);
    wire [31:0] bar1_wr     = (bar1_full & ~wmask) | (cfg_in.wdata & wmask);

    // Serial ROM control word as the host sees it
    wire [31:0] rc_word     = {rom_wdata_q, rom_addr_q, pre_status_q, busy_q, rom_cmd_q,
                               preload_en_q, 1'b0, start_q};

    // Reserved and fixed bytes come from constants only
    wire [31:0] rd_word =
        hit_cmd  ? {30'h0, cmd_mem_q, cmd_io_q} :
        hit_lat  ? {8'h00, PCHEC_HDR_VAL, PCHEC_LAT_VAL, 8'h00} :
        hit_bar0 ? bar0_full :
        hit_bar1 ? bar1_full :
        hit_sub  ? {sub_device_q, sub_vendor_q} :
        hit_cap  ? {24'h0, cap_ptr_q} :
        hit_irq  ? {16'h0, PCHEC_IRQ_PIN_VAL, irq_line_q} :
        hit_rc   ? rc_word : 32'h0;

    // ROM control writes are dropped while an access runs, so fields stay steady
    wire        rc_wr       = cfg_wr & hit_rc & (state_q == ROM_IDLE);
    wire [1:0]  new_cmd     = cfg_in.wdata[PCHEC_RC_CMD_LSB +: 2];
    wire        cmd_legal   = (new_cmd == PCHEC_ROM_WRITE) | (new_cmd == PCHEC_ROM_READ);
    wire        launch      = rc_wr & cfg_in.be[0] & cfg_in.wdata[PCHEC_RC_START] & cmd_legal;
    wire        pre_launch  = rc_wr & cfg_in.be[0] & cfg_in.wdata[PCHEC_RC_PRELOAD] & ~launch;
    wire        rom_fin     = (state_q == ROM_CYCLE) & rom_done;
    wire        pre_fin     = (state_q == ROM_PRELOAD) & preload_done;

    // Space decode
    wire        io_hit      = acc_valid & ~acc_in.mem & cmd_io_q
                              & (acc_in.addr[31:PCHEC_BAR0_LSB] == bar0_q)
                              & ~acc_in.addr[5];
    wire        m_hit       = acc_valid & acc_in.mem & cmd_mem_q
                              & (acc_in.addr[31:PCHEC_BAR1_LSB] == bar1_q);
    wire [2:0]  uofs        = acc_in.addr[2:0];
    pchec_ureg_e usel;
    assign usel =
        (uofs == PCHEC_U_DATA)  ? (acc_in.we ? UREG_TX_DATA   : UREG_RX_DATA)   :
        (uofs == PCHEC_U_CAUSE) ? (acc_in.we ? UREG_QUEUE_CTL : UREG_IRQ_CAUSE) :
        (uofs == PCHEC_U_IRQEN) ? UREG_IRQ_EN :
        (uofs == PCHEC_U_FRAME) ? UREG_FRAME_FMT :
        (uofs == PCHEC_U_HSOUT) ? UREG_HS_OUT :
        (uofs == PCHEC_U_LINK && !acc_in.we) ? UREG_LINK_COND :
        (uofs == PCHEC_U_HSIN && !acc_in.we) ? UREG_HS_IN : UREG_NONE;

    // Configuration answer, one cycle after the request
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_ack_q   <= 1'b0;
            cfg_rdata_q <= 32'h0;
        end else begin
            cfg_ack_q   <= cfg_valid;
            cfg_rdata_q <= cfg_rd ? rd_word : 32'h0;
        end
    end

    // Header storage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cmd_io_q   <= 1'b0;
            cmd_mem_q  <= 1'b0;
            bar0_q     <= PCHEC_BAR0_RST[31:PCHEC_BAR0_LSB];
            bar1_q     <= PCHEC_BAR1_RST[31:PCHEC_BAR1_LSB];
            irq_line_q <= PCHEC_IRQ_LINE_RST;
        end else begin
            if (cfg_wr & hit_cmd & cfg_in.be[0]) begin
                cmd_io_q  <= cfg_in.wdata[PCHEC_CMD_IO_BIT];
                cmd_mem_q <= cfg_in.wdata[PCHEC_CMD_MEM_BIT];
            end
            if (cfg_wr & hit_bar0) begin
                bar0_q <= bar0_wr[31:PCHEC_BAR0_LSB];
            end
            if (cfg_wr & hit_bar1) begin
                bar1_q <= bar1_wr[31:PCHEC_BAR1_LSB];
            end
            if (cfg_wr & hit_irq & cfg_in.be[0]) begin
                irq_line_q <= cfg_in.wdata[7:0];
            end
        end
    end

    // Identity fields change only through preload
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sub_vendor_q <= PCHEC_SUB_RST;
            sub_device_q <= PCHEC_SUB_RST;
            cap_ptr_q    <= PCHEC_CAP_RST;
        end else if (pre_fin && preload_res.status == PCHEC_PRE_OK) begin
            sub_vendor_q <= preload_res.sub_vendor;
            sub_device_q <= preload_res.sub_device;
            cap_ptr_q    <= preload_res.cap_ptr;
        end
    end

    // Serial ROM sequencing
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q      <= ROM_IDLE;
            busy_q       <= 1'b0;
            start_q      <= 1'b0;
            preload_en_q <= 1'b0;
            rom_cmd_q    <= 2'h0;
            rom_addr_q   <= PCHEC_ROMADR_RST;
            rom_wdata_q  <= PCHEC_WBUF_RST;
            pre_status_q <= PCHEC_PRE_NONE;
            rom_go_q     <= 1'b0;
            preload_go_q <= 1'b0;
        end else begin
            rom_go_q     <= launch;
            preload_go_q <= pre_launch;
            if (rc_wr & cfg_in.be[0]) begin
                rom_cmd_q    <= new_cmd;
                preload_en_q <= cfg_in.wdata[PCHEC_RC_PRELOAD];
            end
            if (rc_wr & cfg_in.be[1]) begin
                rom_addr_q <= cfg_in.wdata[PCHEC_RC_ADR_LSB +: 8];
            end
            if (rc_wr & cfg_in.be[2]) begin
                rom_wdata_q[7:0] <= cfg_in.wdata[PCHEC_RC_DAT_LSB +: 8];
            end
            if (rc_wr & cfg_in.be[3]) begin
                rom_wdata_q[15:8] <= cfg_in.wdata[PCHEC_RC_DAT_LSB + 8 +: 8];
            end
            unique case (state_q)
                ROM_IDLE: begin
                    if (launch) begin
                        state_q <= ROM_CYCLE;
                        busy_q  <= 1'b1;
                        start_q <= 1'b1;
                    end else if (pre_launch) begin
                        state_q <= ROM_PRELOAD;
                        busy_q  <= 1'b1;
                    end
                end
                ROM_CYCLE: begin
                    if (rom_done) begin
                        state_q <= ROM_IDLE;
                        busy_q  <= 1'b0;
                        start_q <= 1'b0;
                        if (rom_cmd_q == PCHEC_ROM_READ) begin
                            rom_wdata_q <= rom_rdata;
                        end
                    end
                end
                ROM_PRELOAD: begin
                    if (preload_done) begin
                        state_q      <= ROM_IDLE;
                        busy_q       <= 1'b0;
                        preload_en_q <= 1'b0;
                        pre_status_q <= preload_res.status;
                    end
                end
            endcase
        end
    end

    // Space claims, registered one cycle after the access
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            uart_claim_q <= '{hit: 1'b0, we: 1'b0, chan: 2'h0, sel: UREG_NONE};
            mem_hit_q    <= 1'b0;
            mem_ofs_q    <= 12'h000;
        end else begin
            uart_claim_q.hit  <= io_hit & (usel != UREG_NONE);
            uart_claim_q.we   <= acc_in.we;
            uart_claim_q.chan <= acc_in.addr[4:3];
            uart_claim_q.sel  <= io_hit ? usel : UREG_NONE;
            mem_hit_q         <= m_hit;
            mem_ofs_q         <= acc_in.addr[11:0];
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    AST_LAT_ZERO: assert property (cfg_rd && hit_lat |=> cfg_ack_q && cfg_rdata_q[15:8] == 8'h00)
        else $error("latency byte not zero");
    AST_HDR_TYPE: assert property (cfg_rd && hit_lat |=> cfg_rdata_q[31:16] == 16'h0000)
        else $error("header type dword upper half not zero");
    AST_BAR0_IO: assert property (cfg_rd && hit_bar0 |=> cfg_rdata_q[5:0] == 6'h01)
        else $error("bar0 low bits wrong");
    AST_BAR1_ALIGN: assert property (cfg_rd && hit_bar1 |=> cfg_rdata_q[11:0] == 12'h000)
        else $error("bar1 low bits wrong");
    AST_SUB_RO: assert property (cfg_wr && hit_sub && !pre_fin |=> $stable({sub_device_q, sub_vendor_q}))
        else $error("subsystem codes changed by host write");
    AST_CAP_RD: assert property (cfg_rd && hit_cap |=> cfg_rdata_q == {24'h0, $past(cap_ptr_q)})
        else $error("capability pointer read wrong");
    AST_IRQ_LINE: assert property (cfg_wr && hit_irq && cfg_in.be[0] |=> irq_line_q == $past(cfg_in.wdata[7:0]))
        else $error("routing byte not stored");
    AST_IRQ_PIN: assert property (cfg_rd && hit_irq |=> cfg_rdata_q[31:8] == 24'h000001)
        else $error("interrupt pin dword wrong");
    AST_START_GO: assert property (launch |=> rom_go_q && busy_q
        && rom_addr_q == ($past(cfg_in.be[1]) ? $past(cfg_in.wdata[15:8]) : $past(rom_addr_q)))
        else $error("rom cycle not launched at address");
    AST_CMD_RSVD: assert property (rc_wr && cfg_in.be[0] && !cmd_legal && !cfg_in.wdata[PCHEC_RC_PRELOAD]
        |=> !rom_go_q && !busy_q)
        else $error("reserved command launched a cycle");
    AST_BUSY_HOLD: assert property (rom_go_q && !rom_done |=> busy_q)
        else $error("busy dropped before completion");
    AST_PRE_STATUS: assert property (pre_fin |=> pre_status_q == $past(preload_res.status) && !busy_q)
        else $error("preload outcome not reported");
    AST_WBUF: assert property (rc_wr && cfg_in.be[3:2] == 2'b11 |=> rom_wdata_q == $past(cfg_in.wdata[31:16]))
        else $error("write buffer not loaded");
    AST_CHAN: assert property (io_hit && usel != UREG_NONE |=> uart_claim_q.hit
        && uart_claim_q.chan == $past(acc_in.addr[4:3]))
        else $error("channel decode wrong");
    AST_RO_OFS: assert property (io_hit && acc_in.we && uofs == PCHEC_U_LINK |=> !uart_claim_q.hit)
        else $error("write claimed a read-only register");
    AST_SHARED: assert property (io_hit && uofs == PCHEC_U_DATA |=>
        uart_claim_q.sel == ($past(acc_in.we) ? UREG_TX_DATA : UREG_RX_DATA))
        else $error("data offset direction wrong");
    AST_IO_GATE: assert property (acc_valid && !acc_in.mem && !cmd_io_q |=> !uart_claim_q.hit)
        else $error("io access claimed while disabled");
    AST_DONE_CLR: assert property (rom_fin |=> !busy_q && !start_q && !rom_go_q)
        else $error("completion left start or busy set");

    COV_WRITE_CYCLE: cover property (launch && new_cmd == PCHEC_ROM_WRITE ##[1:50] rom_fin);
    COV_PRELOAD_OK: cover property (pre_fin && preload_res.status == PCHEC_PRE_OK);
    COV_UART_HIT: cover property (uart_claim_q.hit && uart_claim_q.chan == 2'h3);
    COV_MEM_HIT: cover property (mem_hit_q);

endmodule
`default_nettype wire

// ===== rtl/pchec_pkg.sv
package pchec_pkg;

    // Configuration dword offsets (byte addresses)
    localparam logic [7:0]  PCHEC_OFS_CMD     = 8'h04;
    localparam logic [7:0]  PCHEC_OFS_LAT     = 8'h0C;
    localparam logic [7:0]  PCHEC_OFS_BAR0    = 8'h10;
    localparam logic [7:0]  PCHEC_OFS_BAR1    = 8'h14;
    localparam logic [7:0]  PCHEC_OFS_SUBSYS  = 8'h2C;
    localparam logic [7:0]  PCHEC_OFS_CAP     = 8'h34;
    localparam logic [7:0]  PCHEC_OFS_IRQ     = 8'h3C;
    localparam logic [7:0]  PCHEC_OFS_ROMCTL  = 8'hDC;

    // Fixed and reset values
    localparam logic [7:0]  PCHEC_LAT_VAL     = 8'h00;
    localparam logic [7:0]  PCHEC_HDR_VAL     = 8'h00;
    localparam logic [7:0]  PCHEC_IRQ_PIN_VAL = 8'h01;
    localparam logic [7:0]  PCHEC_IRQ_LINE_RST = 8'h00;
    localparam logic [7:0]  PCHEC_CAP_RST     = 8'h00;
    localparam logic [15:0] PCHEC_SUB_RST     = 16'h0000;
    localparam logic [15:0] PCHEC_WBUF_RST    = 16'h0000;
    localparam logic [7:0]  PCHEC_ROMADR_RST  = 8'h00;
    localparam logic [31:0] PCHEC_BAR0_RST    = 32'h00000001;
    localparam logic [31:0] PCHEC_BAR1_RST    = 32'h00000000;

    // Window sizes as low-bit counts: 64 bytes and 4096 bytes
    localparam int          PCHEC_BAR0_LSB    = 6;
    localparam int          PCHEC_BAR1_LSB    = 12;

    // Command register bits
    localparam int          PCHEC_CMD_IO_BIT  = 0;
    localparam int          PCHEC_CMD_MEM_BIT = 1;

    // Serial ROM control fields
    localparam int          PCHEC_RC_START    = 0;
    localparam int          PCHEC_RC_PRELOAD  = 2;
    localparam int          PCHEC_RC_CMD_LSB  = 3;
    localparam int          PCHEC_RC_BUSY     = 5;
    localparam int          PCHEC_RC_PRE_LSB  = 6;
    localparam int          PCHEC_RC_ADR_LSB  = 8;
    localparam int          PCHEC_RC_DAT_LSB  = 16;
    localparam logic [1:0]  PCHEC_ROM_WRITE   = 2'h1;
    localparam logic [1:0]  PCHEC_ROM_READ    = 2'h2;
    localparam logic [1:0]  PCHEC_PRE_NONE    = 2'h0;
    localparam logic [1:0]  PCHEC_PRE_OFF     = 2'h1;
    localparam logic [1:0]  PCHEC_PRE_BADSUM  = 2'h2;
    localparam logic [1:0]  PCHEC_PRE_OK      = 2'h3;

    // Channel register offsets inside one 8-byte block
    localparam logic [2:0]  PCHEC_U_DATA      = 3'h0;
    localparam logic [2:0]  PCHEC_U_IRQEN     = 3'h1;
    localparam logic [2:0]  PCHEC_U_CAUSE     = 3'h2;
    localparam logic [2:0]  PCHEC_U_FRAME     = 3'h3;
    localparam logic [2:0]  PCHEC_U_HSOUT     = 3'h4;
    localparam logic [2:0]  PCHEC_U_LINK      = 3'h5;
    localparam logic [2:0]  PCHEC_U_HSIN      = 3'h6;

    typedef enum logic [3:0] {
        UREG_NONE, UREG_RX_DATA, UREG_TX_DATA, UREG_IRQ_EN, UREG_IRQ_CAUSE,
        UREG_QUEUE_CTL, UREG_FRAME_FMT, UREG_HS_OUT, UREG_LINK_COND, UREG_HS_IN
    } pchec_ureg_e;

    typedef enum logic [1:0] {ROM_IDLE, ROM_CYCLE, ROM_PRELOAD} pchec_rom_e;

    typedef struct packed {
        logic        we;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pchec_cfg_s;

    typedef struct packed {
        logic        mem;
        logic        we;
        logic [31:0] addr;
    } pchec_acc_s;

    typedef struct packed {
        logic        hit;
        logic        we;
        logic [1:0]  chan;
        pchec_ureg_e sel;
    } pchec_claim_s;

    typedef struct packed {
        logic [1:0]  status;
        logic [15:0] sub_vendor;
        logic [15:0] sub_device;
        logic [7:0]  cap_ptr;
    } pchec_pre_s;

endpackage

// ===== tb/pchec_rom_model.sv
`timescale 1ns/1ns
`default_nettype none
module pchec_rom_model
    import pchec_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset,
    // Requests from the control logic
    input  wire logic         rom_go_q,
    input  wire logic [1:0]   rom_cmd_q,
    input  wire logic [7:0]   rom_addr_q,
    input  wire logic [15:0]  rom_wdata_q,
    input  wire logic         preload_go_q,
    // Answers
    output logic              rom_done,
    output logic [15:0]       rom_rdata,
    output logic              preload_done,
    output pchec_pre_s        preload_res,
    // Bench knobs: wait length and preload outcome
    input  wire logic [3:0]   lat,
    input  wire pchec_pre_s   pre_val
);
    logic [15:0] mem [256];
    logic [3:0]  cnt_q;
    logic        busy_q;
    logic        pre_q;
    logic [7:0]  adr_q;

    // Outside a done strobe rom_rdata toggles and preload_res carries the inverted outcome so that a stale sample shows up
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rom_done     <= 1'b0;
            preload_done <= 1'b0;
            rom_rdata    <= 16'h0000;
            preload_res  <= '0;
            busy_q       <= 1'b0;
            pre_q        <= 1'b0;
            cnt_q        <= 4'h0;
            adr_q        <= 8'h00;
        end else begin
            rom_done     <= 1'b0;
            preload_done <= 1'b0;
            rom_rdata    <= ~rom_rdata;
            preload_res  <= ~pre_val;
            if (rom_go_q || preload_go_q) begin
                busy_q <= 1'b1;
                pre_q  <= preload_go_q && !rom_go_q;
                cnt_q  <= lat;
                adr_q  <= rom_addr_q;
                if (rom_go_q && rom_cmd_q == PCHEC_ROM_WRITE) begin
                    mem[rom_addr_q] <= rom_wdata_q;
                end
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    busy_q <= 1'b0;
                    if (pre_q) begin
                        preload_done <= 1'b1;
                        preload_res  <= pre_val;
                    end else begin
                        rom_done  <= 1'b1;
                        rom_rdata <= mem[adr_q];
                    end
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/pci_config_header_eeprom_ctl_test.sv
`timescale 1ns/1ns
`default_nettype none
module pci_config_header_eeprom_ctl_test
    import pchec_pkg::*;
;
    logic         mclk, reset, cfg_valid, cfg_ack_q, acc_valid, mem_hit_q;
    logic         rom_go_q, rom_done, preload_go_q, preload_done;
    logic [31:0]  cfg_rdata_q, r;
    logic [11:0]  mem_ofs_q;
    logic [1:0]   rom_cmd_q;
    logic [7:0]   rom_addr_q, irq_line_q;
    logic [15:0]  rom_wdata_q, rom_rdata;
    logic [3:0]   lat;
    pchec_cfg_s   cfg_in;
    pchec_acc_s   acc_in;
    pchec_claim_s uart_claim_q;
    pchec_pre_s   preload_res, pre_val;
    int           fail_count, total_checks;

    pchec_cfg dut (.mclk(mclk), .reset(reset), .cfg_valid(cfg_valid), .cfg_in(cfg_in), .cfg_ack_q(cfg_ack_q),
        .cfg_rdata_q(cfg_rdata_q), .acc_valid(acc_valid), .acc_in(acc_in), .uart_claim_q(uart_claim_q),
        .mem_hit_q(mem_hit_q), .mem_ofs_q(mem_ofs_q), .rom_go_q(rom_go_q), .rom_cmd_q(rom_cmd_q),
        .rom_addr_q(rom_addr_q), .rom_wdata_q(rom_wdata_q), .rom_done(rom_done), .rom_rdata(rom_rdata),
        .preload_go_q(preload_go_q), .preload_done(preload_done), .preload_res(preload_res),
        .irq_line_q(irq_line_q));
    pchec_rom_model rom (.mclk(mclk), .reset(reset), .rom_go_q(rom_go_q), .rom_cmd_q(rom_cmd_q),
        .rom_addr_q(rom_addr_q), .rom_wdata_q(rom_wdata_q), .preload_go_q(preload_go_q), .rom_done(rom_done),
        .rom_rdata(rom_rdata), .preload_done(preload_done), .preload_res(preload_res), .lat(lat),
        .pre_val(pre_val));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfg_valid <= 1'b1;
        cfg_in    <= '{w, a, 4'hF, d};
        @(posedge mclk);
        cfg_valid <= 1'b0;
        #1;
        chk("ack", 32'h1, {31'h0, cfg_ack_q});
        r = cfg_rdata_q;
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        cfg(1'b0, a, 32'h0);
        chk(n, e, r);
    endtask

    // Polls the busy bit; leaves the last control read in r
    task automatic wait_idle();
        int n;
        n = 0;
        r = 32'h20;
        while (r[5] !== 1'b0 && n < 40) begin
            cfg(1'b0, PCHEC_OFS_ROMCTL, 32'h0);
            n++;
        end
        chk("idle", 32'h0, {31'h0, r[5]});
    endtask

    task automatic acc(input logic m, input logic w, input logic [31:0] a);
        @(posedge mclk);
        acc_valid <= 1'b1;
        acc_in    <= '{m, w, a};
        @(posedge mclk);
        acc_valid <= 1'b0;
        #1;
    endtask

    function automatic pchec_ureg_e esel(input logic [2:0] o, input logic w);
        case (o)
            3'h0: return w ? UREG_TX_DATA : UREG_RX_DATA;
            3'h1: return UREG_IRQ_EN;
            3'h2: return w ? UREG_QUEUE_CTL : UREG_IRQ_CAUSE;
            3'h3: return UREG_FRAME_FMT;
            3'h4: return UREG_HS_OUT;
            3'h5: return w ? UREG_NONE : UREG_LINK_COND;
            3'h6: return w ? UREG_NONE : UREG_HS_IN;
            default: return UREG_NONE;
        endcase
    endfunction

    task automatic t_regs();
        rd("lat", PCHEC_OFS_LAT, 32'h0);
        rd("bar0", PCHEC_OFS_BAR0, 32'h1);
        rd("bar1", PCHEC_OFS_BAR1, 32'h0);
        rd("sub", PCHEC_OFS_SUBSYS, 32'h0);
        rd("cap", PCHEC_OFS_CAP, 32'h0);
        rd("irq", PCHEC_OFS_IRQ, 32'h100);
        rd("romctl", PCHEC_OFS_ROMCTL, 32'h0);
        cfg(1'b1, PCHEC_OFS_LAT, 32'hFFFFFFFF);
        cfg(1'b1, PCHEC_OFS_SUBSYS, 32'hFFFFFFFF);
        cfg(1'b1, PCHEC_OFS_CAP, 32'hFFFFFFFF);
        cfg(1'b1, PCHEC_OFS_IRQ, 32'hFFFFFFFF);
        cfg(1'b1, PCHEC_OFS_BAR0, 32'hFFFFFFFF);
        cfg(1'b1, PCHEC_OFS_BAR1, 32'hFFFFFFFF);
        rd("lat_ro", PCHEC_OFS_LAT, 32'h0);
        rd("sub_ro", PCHEC_OFS_SUBSYS, 32'h0);
        rd("cap_ro", PCHEC_OFS_CAP, 32'h0);
        rd("irq_rw", PCHEC_OFS_IRQ, 32'h1FF);
        chk("irq_line", 32'hFF, {24'h0, irq_line_q});
        rd("bar0_sz", PCHEC_OFS_BAR0, 32'hFFFFFFC1);
        rd("bar1_sz", PCHEC_OFS_BAR1, 32'hFFFFF000);
    endtask

    task automatic t_rom();
        lat <= 4'h8;
        cfg(1'b1, PCHEC_OFS_ROMCTL, 32'h12340509);
        chk("go", {5'h0, 1'b1, PCHEC_ROM_WRITE, 8'h05, 16'h1234},
            {5'h0, rom_go_q, rom_cmd_q, rom_addr_q, rom_wdata_q});
        cfg(1'b0, PCHEC_OFS_ROMCTL, 32'h0);
        chk("busy", 32'h3, {30'h0, r[5], r[0]});
        wait_idle();
        chk("start_clr", 32'h0, {31'h0, r[0]});
        lat <= 4'h0;
        cfg(1'b1, PCHEC_OFS_ROMCTL, 32'h00000511);
        chk("go_rd", {5'h0, 1'b1, PCHEC_ROM_READ}, {5'h0, rom_go_q, rom_cmd_q});
        wait_idle();
        chk("rdata", 32'h1234, {16'h0, r[31:16]});
        cfg(1'b1, PCHEC_OFS_ROMCTL, 32'h00000519);
        chk("go_res3", 32'h0, {31'h0, rom_go_q});
        cfg(1'b1, PCHEC_OFS_ROMCTL, 32'h00000501);
        chk("go_res0", 32'h0, {31'h0, rom_go_q});
        cfg(1'b0, PCHEC_OFS_ROMCTL, 32'h0);
        chk("no_start", 32'h0, {30'h0, r[5], r[0]});
    endtask

    task automatic t_preload(input logic [1:0] st, input logic [31:0] sub, input logic [31:0] cap);
        pre_val <= '{st, 16'hA5A5, 16'h5A5A, 8'h40};
        lat     <= 4'h3;
        cfg(1'b1, PCHEC_OFS_ROMCTL, 32'h4);
        chk("pre_go", 32'h1, {31'h0, preload_go_q});
        wait_idle();
        chk("pre_st", {29'h0, st, 1'b0}, {29'h0, r[7:6], r[2]});
        rd("pre_sub", PCHEC_OFS_SUBSYS, sub);
        rd("pre_cap", PCHEC_OFS_CAP, cap);
    endtask

    task automatic t_space();
        cfg(1'b1, PCHEC_OFS_BAR0, 32'h00001000);
        cfg(1'b1, PCHEC_OFS_CMD, 32'h0);
        acc(1'b0, 1'b0, 32'h00001001);
        chk("io_off", 32'h0, {31'h0, uart_claim_q.hit});
        cfg(1'b1, PCHEC_OFS_CMD, 32'h1);
        for (int c = 0; c < 4; c++) begin
            for (int o = 0; o < 16; o++) begin
                acc(1'b0, o[3], 32'h1000 + 32'(c * 8 + o[2:0]));
                chk("claim", {24'h0, o[3], esel(o[2:0], o[3]) != UREG_NONE,
                    (esel(o[2:0], o[3]) != UREG_NONE) ? 2'(c) : 2'h0, esel(o[2:0], o[3])},
                    {24'h0, uart_claim_q.we, uart_claim_q.hit, uart_claim_q.hit ? uart_claim_q.chan : 2'h0,
                    uart_claim_q.sel});
            end
        end
        cfg(1'b1, PCHEC_OFS_BAR1, 32'h00002000);
        acc(1'b1, 1'b0, 32'h00002345);
        chk("mem_off", 32'h0, {31'h0, mem_hit_q});
        cfg(1'b1, PCHEC_OFS_CMD, 32'h3);
        acc(1'b1, 1'b1, 32'h00002345);
        chk("mem_hit", 32'h1345, {19'h0, mem_hit_q, mem_ofs_q});
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this bound is generous
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end

    initial begin
        reset     = 1'b1;
        cfg_valid = 1'b0;
        cfg_in    = '0;
        acc_valid = 1'b0;
        acc_in    = '0;
        lat       = 4'h0;
        pre_val   = '0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_rom();
        t_preload(PCHEC_PRE_OFF, 32'h0, 32'h0);
        t_preload(PCHEC_PRE_BADSUM, 32'h0, 32'h0);
        t_preload(PCHEC_PRE_OK, 32'h5A5AA5A5, 32'h40);
        t_space();
        print_verdict();
    end
endmodule
`default_nettype wire
